// ===== logic/pst_pkg.sv
// shared constants, register map and carrier types of the packet assembly service timer
package pst_pkg;

  // timer count and field widths
  localparam int NUM_TIMERS  = 16;
  localparam int TNUM_W      = 4;
  localparam int IDX_W       = 16;
  localparam int BASE_W      = 16;
  localparam int IPF_W       = 8;
  localparam int CONN_W      = 15;
  localparam int PTR_W       = 16;
  localparam int MEM_AW      = 21;

  // external address units: timer base in 32-byte units, indicator is one 4-byte word
  localparam int BASE_SHIFT  = 5;
  localparam int IND_SHIFT   = 2;

  // axi4-lite register map (byte addresses)
  localparam int              AXI_AW       = 12;
  localparam logic [11:0]     OFS_CTRL     = 12'h000;
  localparam logic [11:0]     OFS_STATUS   = 12'h004;
  localparam logic [11:0]     OFS_TDM_PTR  = 12'h008;
  localparam logic [11:0]     OFS_CTL_BASE = 12'h100;
  localparam logic [11:0]     OFS_CTL_END  = 12'h2ff;
  localparam logic [31:0]     CTRL_RESET   = 32'h0000_0000;

  // field index inside one 32-byte control entry window
  localparam logic [2:0]      FLD_PHASE    = 3'h0;
  localparam logic [2:0]      FLD_IPF      = 3'h1;
  localparam logic [2:0]      FLD_BASE     = 3'h2;
  localparam logic [2:0]      FLD_RD_IDX   = 3'h3;
  localparam logic [2:0]      FLD_LAST     = 3'h4;

  // axi responses
  localparam logic [1:0]      RESP_OKAY    = 2'h0;
  localparam logic [1:0]      RESP_SLVERR  = 2'h2;

  // indicator word bit positions
  localparam int IND_SCAN    = 31;
  localparam int IND_ACT     = 30;
  localparam int IND_ASM     = 29;
  localparam int IND_SIL     = 28;
  localparam int IND_TNUM_LO = 24;
  localparam int IND_FRM_LO  = 16;
  localparam int IND_CONN_LO = 0;

  // one control memory entry
  typedef struct packed {
    logic [15:0]        phase_base;
    logic [IPF_W-1:0]   ipf;
    logic [BASE_W-1:0]  timer_base;
    logic [IDX_W-1:0]   rd_idx;
    logic [IDX_W-1:0]   last_idx;
  } pst_ctl_type;

  // event handed to the packet assembly logic
  typedef struct packed {
    logic               scan;
    logic               channel_activate_flag;
    logic               assemble;
    logic               silence;
    logic               hdlc;
    logic               phased;
    logic [TNUM_W-1:0]  timer_num;
    logic [7:0]         block_frames;
    logic [CONN_W-1:0]  conn_base;
    logic [PTR_W-1:0]   tdm_ptr;
  } pst_event_type;

endpackage

// ===== logic/pst_service_timer.sv
// packet assembly service timer: control memory, frame sequencer, event issue, axi4-lite slave
//
// Summary of operation
// - up to sixteen independent timers in external memory, each own length and rate
// - each timer reads a fixed group of consecutive indicators per frame
// - each tdm write pointer increment triggers one full frame read of every enabled timer
// - an indicator may request a voice packet attempt and a silence calculation
// - assembly builds only when enough tdm bytes accumulated since previous assembly end
// - hdlc packet assembly is requested directly, without any timer indicator
// - silence event asks for local and remote energy verdict deciding packet send
// - silence block length equals the frame count carried by the packet
// - start of frame scan events placed sparsely lower the scan rate
// - sixteen-entry internal control memory holds every timer's configuration
// - each entry has a phase buffer pointer; zero disables phasing
// - each entry holds the number of indicators read per frame
// - each entry holds timer start address in first bank, 32-byte units
// - per timer next indicator index kept; software zeroes it before running
// - length field holds timer length in indicators minus one
// - a set scan flag starts the transmit aal2 vc time-out scan
// - only an indicator with activate flag set may power up a channel
// - indicator carries timer number and connection base bits 20 to 6
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps

module pst_service_timer
  import pst_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  ce_i,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0]     s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [AXI_AW-1:0]     s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // tdm writer
  input  wire logic                  tdm_wr_inc_i,
  input  wire logic [PTR_W-1:0]      tdm_wr_ptr_i,
  // first static memory bank read port
  output logic                       mem_req_o,
  output logic [MEM_AW-1:0]          mem_addr_o,
  input  wire logic                  mem_ack_i,
  input  wire logic [31:0]           mem_rdata_i,
  // hdlc completion from the hdlc receiver
  input  wire logic                  hdlc_done_i,
  input  wire logic [CONN_W-1:0]     hdlc_conn_i,
  // event stream to packet assembly
  output pst_event_type              event_o,
  output logic                       event_valid_o,
  input  wire logic                  event_ready_i,
  // byte-availability check for assembly attempts
  input  wire logic                  chk_valid_i,
  input  wire logic [PTR_W-1:0]      chk_prev_end_i,
  input  wire logic [PTR_W-1:0]      chk_need_i,
  output logic                       chk_done_o,
  output logic                       chk_build_o
);

  typedef enum logic [2:0] {
    SQ_IDLE,
    SQ_PICK,
    SQ_REQ,
    SQ_WAIT,
    SQ_EMIT
  } pst_seq_type;

  // control memory, one entry per timer
  pst_ctl_type                 ctl [NUM_TIMERS];
  logic [31:0]                 ctrl;
  logic [PTR_W-1:0]            tdm_ptr;
  logic                        frame_pend;
  logic                        hdlc_pend;
  logic [CONN_W-1:0]           hdlc_conn;
  logic [7:0]                  overrun_cnt;
  pst_seq_type                 seq;
  logic [TNUM_W-1:0]           cur_t;
  logic [IPF_W-1:0]            left;
  logic [31:0]                 ind;

  // axi write holding state
  logic                        aw_hold;
  logic                        w_hold;
  logic [AXI_AW-1:0]           aw_addr;
  logic [31:0]                 w_data;
  logic [3:0]                  w_strb;

  // shared decode
  wire pst_ctl_type            cur_ctl     = ctl[cur_t];
  wire logic                   start_wr    = aw_hold & w_hold & ~s_axi_bvalid_o;
  wire logic                   wr_in_ctl   = (aw_addr >= OFS_CTL_BASE) && (aw_addr <= OFS_CTL_END);
  wire logic [TNUM_W-1:0]      wr_t        = {~aw_addr[8], aw_addr[7:5]};
  wire logic [2:0]             wr_f        = aw_addr[4:2];
  wire logic                   wr_ctl_hit  = wr_in_ctl && (wr_f <= FLD_LAST);
  wire logic                   wr_ctrl_hit = (aw_addr == OFS_CTRL);
  wire logic                   wr_ok       = wr_ctl_hit | wr_ctrl_hit;
  wire logic                   wr_ctl_en   = start_wr & wr_ctl_hit;

  // sequencer decode
  wire logic                   frame_tick  = ce_i & tdm_wr_inc_i;
  wire logic                   t_active    = ctrl[cur_t] && (cur_ctl.ipf != '0);
  wire logic                   last_t      = (cur_t == TNUM_W'(NUM_TIMERS - 1));
  wire logic                   ind_taken   = (seq == SQ_WAIT) & mem_ack_i;
  wire logic                   at_last     = (cur_ctl.rd_idx == cur_ctl.last_idx);
  wire logic [IDX_W-1:0]       next_rd_idx = at_last ? '0 : cur_ctl.rd_idx + 1'b1;
  wire logic [MEM_AW-1:0]      ind_addr    = (MEM_AW'(cur_ctl.timer_base) << BASE_SHIFT)
                                           + (MEM_AW'(cur_ctl.rd_idx) << IND_SHIFT);
  wire logic                   ev_free     = ~event_valid_o | event_ready_i;
  wire logic                   ind_useful  = ind[IND_SCAN] | ind[IND_ACT]
                                           | ind[IND_ASM] | ind[IND_SIL];
  wire logic                   seq_emit    = (seq == SQ_EMIT) & ev_free;
  wire logic                   hdlc_emit   = (seq == SQ_IDLE) & ~frame_pend & hdlc_pend & ev_free;
  wire logic                   group_done  = (left == IPF_W'(1));
  wire logic [PTR_W-1:0]       avail       = tdm_ptr - chk_prev_end_i;

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // old value of the addressed control field, low aligned
  logic [31:0] ctl_field_old;
  always_comb begin
    ctl_field_old = '0;
    unique case (wr_f)
      FLD_PHASE:  ctl_field_old = 32'(ctl[wr_t].phase_base);
      FLD_IPF:    ctl_field_old = 32'(ctl[wr_t].ipf);
      FLD_BASE:   ctl_field_old = 32'(ctl[wr_t].timer_base);
      FLD_RD_IDX: ctl_field_old = 32'(ctl[wr_t].rd_idx);
      FLD_LAST:   ctl_field_old = 32'(ctl[wr_t].last_idx);
      default:    ctl_field_old = '0;
    endcase
  end
  wire logic [31:0]            ctl_field_new = merge_bytes(ctl_field_old, w_data, w_strb);

  // axi write channels: address and data taken in either order, answer after both
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      aw_hold         <= 1'b0;
      w_hold          <= 1'b0;
      aw_addr         <= '0;
      w_data          <= '0;
      w_strb          <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else if (ce_i) begin
      s_axi_awready_o <= ~aw_hold & ~(s_axi_awvalid_i & s_axi_awready_o) & ~s_axi_bvalid_o;
      s_axi_wready_o  <= ~w_hold & ~(s_axi_wvalid_i & s_axi_wready_o) & ~s_axi_bvalid_o;
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (start_wr) begin
        aw_hold        <= 1'b0;
        w_hold         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // global control: per timer run enable bits
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (ce_i && start_wr && wr_ctrl_hit) begin
      ctrl <= merge_bytes(ctrl, w_data, w_strb) & 32'h0000_ffff;
    end
  end

  // control memory: software writes and the hardware index advance;
  // software wins a same-cycle clash so that initialisation is never undone
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        ctl[t] <= '0;
      end
    end else if (ce_i) begin
      if (ind_taken) begin
        ctl[cur_t].rd_idx <= next_rd_idx;
      end
      if (wr_ctl_en) begin
        unique case (wr_f)
          FLD_PHASE:  ctl[wr_t].phase_base <= ctl_field_new[15:0];
          FLD_IPF:    ctl[wr_t].ipf        <= ctl_field_new[IPF_W-1:0];
          FLD_BASE:   ctl[wr_t].timer_base <= ctl_field_new[BASE_W-1:0];
          FLD_RD_IDX: ctl[wr_t].rd_idx     <= ctl_field_new[IDX_W-1:0];
          FLD_LAST:   ctl[wr_t].last_idx   <= ctl_field_new[IDX_W-1:0];
          default:    ;
        endcase
      end
    end
  end

  // read decode: control fields, control word, status and live pointer
  wire logic                   rd_in_ctl = (s_axi_araddr_i >= OFS_CTL_BASE)
                                         && (s_axi_araddr_i <= OFS_CTL_END);
  wire pst_ctl_type            rd_ctl    = ctl[{~s_axi_araddr_i[8], s_axi_araddr_i[7:5]}];
  wire logic [2:0]             rd_f      = s_axi_araddr_i[4:2];
  wire logic [31:0]            status    = {16'h0000, overrun_cnt, cur_t,
                                            hdlc_pend, frame_pend, 1'b0, seq != SQ_IDLE};
  logic [31:0]                 rd_word;
  logic                        rd_ok;
  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    if (rd_in_ctl) begin
      unique case (rd_f)
        FLD_PHASE:  rd_word = 32'(rd_ctl.phase_base);
        FLD_IPF:    rd_word = 32'(rd_ctl.ipf);
        FLD_BASE:   rd_word = 32'(rd_ctl.timer_base);
        FLD_RD_IDX: rd_word = 32'(rd_ctl.rd_idx);
        FLD_LAST:   rd_word = 32'(rd_ctl.last_idx);
        default:    rd_ok   = 1'b0;
      endcase
    end else if (s_axi_araddr_i == OFS_CTRL) begin
      rd_word = ctrl;
    end else if (s_axi_araddr_i == OFS_STATUS) begin
      rd_word = status;
    end else if (s_axi_araddr_i == OFS_TDM_PTR) begin
      rd_word = 32'(tdm_ptr);
    end else begin
      rd_ok = 1'b0;
    end
  end

  // axi read channel: one cycle address accept, data registered on the accepting edge
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (ce_i) begin
      s_axi_arready_o <= ~s_axi_rvalid_o & ~(s_axi_arvalid_i & s_axi_arready_o);
      if (s_axi_arvalid_i & s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_word;
        s_axi_rresp_o   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o & s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // frame pulse and hdlc requests are sticky; a new event beats its own clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tdm_ptr     <= '0;
      frame_pend  <= 1'b0;
      hdlc_pend   <= 1'b0;
      hdlc_conn   <= '0;
      overrun_cnt <= '0;
    end else if (ce_i) begin
      if (tdm_wr_inc_i) begin
        tdm_ptr <= tdm_wr_ptr_i;
      end
      if (frame_tick) begin
        frame_pend <= 1'b1;
        if (frame_pend || seq != SQ_IDLE) begin
          overrun_cnt <= overrun_cnt + 1'b1;   // frame cannot finish before the next
        end
      end else if (seq == SQ_IDLE && frame_pend) begin
        frame_pend <= 1'b0;
      end
      if (hdlc_done_i) begin
        hdlc_pend <= 1'b1;
        hdlc_conn <= hdlc_conn_i;
      end else if (hdlc_emit) begin
        hdlc_pend <= 1'b0;
      end
    end
  end

  // frame sequencer: walk all timers, read each enabled one's group of indicators
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      seq        <= SQ_IDLE;
      cur_t      <= '0;
      left       <= '0;
      ind        <= '0;
      mem_req_o  <= 1'b0;
      mem_addr_o <= '0;
    end else if (ce_i) begin
      unique case (seq)
        SQ_IDLE: begin
          if (frame_pend) begin
            cur_t <= '0;
            seq   <= SQ_PICK;
          end
        end
        SQ_PICK: begin
          if (t_active) begin
            left <= cur_ctl.ipf;
            seq  <= SQ_REQ;
          end else if (last_t) begin
            seq <= SQ_IDLE;
          end else begin
            cur_t <= cur_t + 1'b1;
          end
        end
        SQ_REQ: begin
          mem_req_o  <= 1'b1;
          mem_addr_o <= ind_addr;
          seq        <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            ind       <= mem_rdata_i;
            seq       <= SQ_EMIT;
          end
        end
        SQ_EMIT: begin
          if (ev_free) begin
            left <= left - 1'b1;
            if (!group_done) begin
              seq <= SQ_REQ;
            end else if (last_t) begin
              seq <= SQ_IDLE;
            end else begin
              cur_t <= cur_t + 1'b1;
              seq   <= SQ_PICK;
            end
          end
        end
      endcase
    end
  end

  // event register: indicator events win over hdlc, which waits for an idle slot
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      event_o       <= '0;
      event_valid_o <= 1'b0;
    end else if (ce_i) begin
      if (seq_emit) begin
        event_valid_o                 <= ind_useful;   // empty slots are not passed on
        event_o.scan                  <= ind[IND_SCAN];
        event_o.channel_activate_flag <= ind[IND_ACT];
        event_o.assemble              <= ind[IND_ASM];
        event_o.silence               <= ind[IND_SIL];
        event_o.hdlc                  <= 1'b0;
        event_o.phased                <= (cur_ctl.phase_base != '0);
        event_o.timer_num             <= ind[IND_TNUM_LO +: TNUM_W];
        event_o.block_frames          <= ind[IND_FRM_LO +: 8];
        event_o.conn_base             <= ind[IND_CONN_LO +: CONN_W];
        event_o.tdm_ptr               <= tdm_ptr;
      end else if (hdlc_emit) begin
        event_valid_o <= 1'b1;
        event_o       <= '0;
        event_o.hdlc      <= 1'b1;
        event_o.assemble  <= 1'b1;
        event_o.conn_base <= hdlc_conn;
        event_o.tdm_ptr   <= tdm_ptr;
      end else if (event_ready_i) begin
        event_valid_o <= 1'b0;
      end
    end
  end

  // assembly attempt check: build only once enough bytes have arrived
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      chk_done_o  <= 1'b0;
      chk_build_o <= 1'b0;
    end else if (ce_i) begin
      chk_done_o  <= chk_valid_i;
      chk_build_o <= chk_valid_i && (avail >= chk_need_i);
    end
  end

endmodule

// ===== test/pst_mem_model.sv
// behavioural first static memory bank answering indicator reads
`timescale 1ns/100ps
module pst_mem_model
  import pst_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  // read port facing the sequencer
  input  wire logic              mem_req_i,
  input  wire logic [MEM_AW-1:0] mem_addr_i,
  output logic                   mem_ack_o,
  output logic [31:0]            mem_rdata_o
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_q;
  initial {mem_ack_o, mem_rdata_o, wait_q} = '0;
  // random latency; data toggles when idle so a stale word never passes for a fresh one
  always @(posedge mclk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (sys_rst_i) begin
      wait_q <= 2'h0;
    end else if (mem_req_i && !mem_ack_o) begin
      if (wait_q == 2'h0) begin
        mem_ack_o <= 1'b1;
        mem_rdata_o <= mem[mem_addr_i[9:2]];
        wait_q <= 2'($urandom);
      end else wait_q <= wait_q - 2'h1;
    end
  end
endmodule

// ===== test/pst_service_timer_assertions.sv
// port-level checker bound to the service timer
`timescale 1ns/100ps
module pst_checker
  import pst_pkg::*;
(
  // clock, reset, enable
  input wire logic              mclk_i,
  input wire logic              sys_rst_i,
  input wire logic              ce_i,
  // watched signals
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [1:0]        s_axi_bresp_o,
  input wire logic              tdm_wr_inc_i,
  input wire logic [PTR_W-1:0]  tdm_wr_ptr_i,
  input wire logic              mem_req_o,
  input wire logic [MEM_AW-1:0] mem_addr_o,
  input wire logic              mem_ack_i,
  input wire pst_event_type     event_o,
  input wire logic              event_valid_o,
  input wire logic              event_ready_i,
  input wire logic              chk_valid_i,
  input wire logic [PTR_W-1:0]  chk_prev_end_i,
  input wire logic [PTR_W-1:0]  chk_need_i,
  input wire logic              chk_done_o,
  input wire logic              chk_build_o
);
  logic [PTR_W-1:0] ptr_q;
  logic             want_build;
  // own copy of the last sampled pointer; the difference wraps on purpose
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) ptr_q <= '0;
    else if (ce_i && tdm_wr_inc_i) ptr_q <= tdm_wr_ptr_i;
  end
  assign want_build = PTR_W'(ptr_q - chk_prev_end_i) >= chk_need_i;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // memory side
  mem_hold_a:
    assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request not held");
  addr_align_a: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
    else $error("indicator address misaligned");
  ack_drop_a: assert property (mem_req_o && mem_ack_i && ce_i |=> !mem_req_o)
    else $error("request kept after answer");
  // event stream
  event_hold_a:
    assert property (event_valid_o && !event_ready_i |=> event_valid_o && $stable(event_o))
    else $error("event changed while stalled");
  flag_needed_a: assert property (event_valid_o && !event_o.hdlc |-> |event_o[48:45])
    else $error("event without any flag");
  // availability check and write response
  chk_time_a:
    assert property (chk_valid_i && ce_i |=> chk_done_o && chk_build_o == $past(want_build))
    else $error("check answer wrong");
  chk_quiet_a: assert property (ce_i && !chk_valid_i |=> !chk_done_o)
    else $error("check answer without request");
  bresp_hold_a:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response not held");
endmodule

bind pst_service_timer pst_checker chk (.mclk_i, .sys_rst_i, .ce_i, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_bresp_o, .tdm_wr_inc_i, .tdm_wr_ptr_i, .mem_req_o, .mem_addr_o,
  .mem_ack_i, .event_o, .event_valid_o, .event_ready_i, .chk_valid_i, .chk_prev_end_i,
  .chk_need_i, .chk_done_o, .chk_build_o);

// ===== test/tb_packet_assembly_service_timer.sv
// self-checking bench for the packet assembly service timer
`timescale 1ns/100ps
module tb_packet_assembly_service_timer
  import pst_pkg::*;
();
  logic mclk_i, sys_rst_i, ce_i, tdm_wr_inc_i, hdlc_done_i, event_ready_i, chk_valid_i;
  logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic mem_ack_i, mem_req_o, event_valid_o, chk_done_o, chk_build_o;
  logic [AXI_AW-1:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]       s_axi_wdata_i, s_axi_rdata_o, mem_rdata_i;
  logic [3:0]        s_axi_wstrb_i;
  logic [1:0]        s_axi_bresp_o, s_axi_rresp_o;
  logic [PTR_W-1:0]  tdm_wr_ptr_i, chk_prev_end_i, chk_need_i, ptr;
  logic [MEM_AW-1:0] mem_addr_o;
  logic [CONN_W-1:0] hdlc_conn_i;
  pst_event_type     event_o;
  pst_event_type     exp_q[$];
  int                bad_count, check_count;
  // two timers with different groups, lengths, bases and phasing
  int tm[2] = '{0, 5};
  int ipf[2] = '{2, 3};
  int lst[2] = '{4, 6};
  int bs[2] = '{2, 10};
  int ph[2] = '{0, 'h40};
  int idx[2] = '{0, 0};

  pst_service_timer uut (.*);
  pst_mem_model mm (.mclk_i, .sys_rst_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
                    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic fail(string m);
    bad_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic cmp(logic [63:0] got, logic [63:0] want, string m);
    check_count++;
    if (got !== want) fail(m);
  endtask
  // one write; valids drop as each channel is taken, bready held until bvalid
  task automatic axw(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge mclk_i);
    {s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    cmp(s_axi_bresp_o, er, "bresp");
  endtask
  task automatic axr(logic [11:0] a, logic [31:0] w, logic [1:0] er);
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    cmp({s_axi_rresp_o, s_axi_rdata_o}, {er, w}, "read");
  endtask
  task automatic drain();
    repeat (40) @(posedge mclk_i);
    for (int n = 0; n < 2000 && exp_q.size() != 0; n++) @(posedge mclk_i);
    cmp(exp_q.size(), 0, "missing event");
  endtask
  function automatic logic [11:0] fa(int t, logic [2:0] fl);
    return OFS_CTL_BASE + {3'h0, 4'(t), 5'h0} + {7'h0, fl, 2'h0};
  endfunction
  function automatic pst_event_type ev_of(logic [31:0] w, logic [15:0] p, logic phd);
    return '{w[31], w[30], w[29], w[28], 1'b0, phd, w[27:24], w[23:16], w[14:0], p};
  endfunction

  // accepts events with random stalls and matches them in order
  initial begin
    event_ready_i = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (event_valid_o === 1'b1 && event_ready_i === 1'b1) begin
        if (exp_q.size() == 0) fail("unexpected event");
        else cmp(event_o, exp_q.pop_front(), "event");
      end
      event_ready_i <= 1'($urandom_range(1, 0));
    end
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    fail("watchdog timeout");
    give_verdict();
  end

  initial begin
    logic [31:0]       w;
    logic [15:0]       pe, nd;
    logic [CONN_W-1:0] c;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {tdm_wr_inc_i, hdlc_done_i, chk_valid_i, hdlc_conn_i, tdm_wr_ptr_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, chk_prev_end_i, chk_need_i} = '0;
    {s_axi_wstrb_i, ce_i, sys_rst_i} = 6'h3f;
    void'($urandom(95172));
    for (int k = 0; k < 256; k++) mm.mem[k] = $urandom;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    axr(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    axr(12'h300, 32'h0, RESP_SLVERR);
    axw(OFS_TDM_PTR, 32'h1, RESP_SLVERR);
    for (int j = 0; j < 2; j++) begin
      axw(fa(tm[j], FLD_PHASE), ph[j], RESP_OKAY);
      axw(fa(tm[j], FLD_IPF), ipf[j], RESP_OKAY);
      axw(fa(tm[j], FLD_BASE), bs[j], RESP_OKAY);
      axw(fa(tm[j], FLD_RD_IDX), 32'h0, RESP_OKAY);
      axw(fa(tm[j], FLD_LAST), lst[j], RESP_OKAY);
      axr(fa(tm[j], FLD_LAST), lst[j], RESP_OKAY);
    end
    axw(OFS_CTRL, 32'h21, RESP_OKAY);
    // frames: expected indicators follow each timer's group and wrap
    for (int f = 0; f < 4; f++) begin
      ptr = 16'($urandom);
      for (int j = 0; j < 2; j++) for (int k = 0; k < ipf[j]; k++) begin
        w = mm.mem[bs[j] * 8 + idx[j]];
        if (w[31:28] != 4'h0) exp_q.push_back(ev_of(w, ptr, ph[j] != 0));
        idx[j] = (idx[j] == lst[j]) ? 0 : idx[j] + 1;
      end
      @(posedge mclk_i);
      {tdm_wr_inc_i, tdm_wr_ptr_i} <= {1'b1, ptr};
      @(posedge mclk_i);
      tdm_wr_inc_i <= 1'b0;
      drain();
    end
    for (int j = 0; j < 2; j++) axr(fa(tm[j], FLD_RD_IDX), idx[j], RESP_OKAY);
    c = CONN_W'($urandom);
    exp_q.push_back('{hdlc: 1'b1, assemble: 1'b1, conn_base: c, tdm_ptr: ptr,
                      default: '0});
    @(posedge mclk_i);
    {hdlc_done_i, hdlc_conn_i} <= {1'b1, c};
    @(posedge mclk_i);
    hdlc_done_i <= 1'b0;
    drain();
    // the first request needs exactly the bytes available, the second one byte more
    for (int k = 0; k < 8; k++) begin
      pe = 16'($urandom);
      nd = 16'((k < 2) ? ptr - pe + k : $urandom);
      @(posedge mclk_i);
      {chk_valid_i, chk_prev_end_i, chk_need_i} <= {1'b1, pe, nd};
      @(posedge mclk_i);
      chk_valid_i <= 1'b0;
      @(posedge mclk_i);
      cmp({chk_done_o, chk_build_o}, {1'b1, 16'(ptr - pe) >= nd}, "check");
    end
    give_verdict();
  end
endmodule
